/* File: rtl/asrt_core.sv */
// Asynchronous serial transmit/receive core with mode, holding and status registers
`timescale 1ns/100ps
`include "asrt_defines.svh"
module asrt_core
	import asrt_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic ARST_N_IN,
	// Base clock falling-edge strobe, sixteen per bit, and bit order
	input wire logic BASE_TICK_IN,
	input wire logic MSB_FIRST_IN,
	// Register port
	input wire logic [15:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [7:0] REG_WDATA_IN,
	output logic [7:0] REG_RDATA_OUT,
	// Serial pins
	input wire logic SERIAL_IN_PIN_IN,
	output logic SERIAL_OUT_PIN_OUT,
	// Event pulses
	output logic RECEIVE_DONE_IRQ_OUT,
	output logic RECEIVE_ERROR_IRQ_OUT,
	output logic TRANSMIT_DONE_IRQ_OUT
);
	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++)
		begin
			r[i] = v[7 - i];
		end
		return r;
	endfunction

	// Wire order of data bits, bit 0 first, unused top bit zero
	function automatic logic [7:0] wire_order(input logic [7:0] d, input logic cl,
		input logic msb);
		logic [7:0] o;
		o = msb ? rev8(d) : d;
		if (!cl)
		begin
			o[7] = 1'b0;
		end
		return o;
	endfunction

	logic [7:0] mode_q;
	logic [7:0] hold_q;
	logic hold_full_q;
	logic tx_busy_q;
	logic [11:0] tx_frame_q;
	logic [3:0] tx_left_q;
	logic [3:0] tx_ovs_q;
	logic tx_out_q;
	logic tx_irq_q;
	logic pwr_rdy_q;
	logic txe_s_q;
	logic rxe_s_q;
	logic rx_s1_q;
	logic rx_s2_q;
	asrt_rx_state_t rx_st_q;
	logic [3:0] rx_ovs_q;
	logic [2:0] rx_nb_q;
	logic [7:0] rx_sh_q;
	logic rx_par_q;
	logic [2:0] err_q;
	logic rx_done_irq_q;
	logic rx_err_irq_q;
	logic [7:0] fifo_q [2];
	logic fifo_wp_q;
	logic fifo_rp_q;
	logic [1:0] fifo_cnt_q;
	logic [7:0] rdata_q;

	// Mode fields and register decode
	wire power = mode_q[`ASRT_POWER_BIT];
	wire [1:0] par_sel = {mode_q[`ASRT_PS_HI_BIT], mode_q[`ASRT_PS_LO_BIT]};
	wire cl = mode_q[`ASRT_CL_BIT];
	wire sl = mode_q[`ASRT_SL_BIT];
	wire isrm = mode_q[`ASRT_ISRM_BIT];
	wire mode_wr = REG_WR_IN && (REG_ADDR_IN == `ASRT_MODE_ADDR);
	wire hold_wr = REG_WR_IN && (REG_ADDR_IN == `ASRT_HOLD_ADDR);
	wire err_rd = REG_RD_IN && (REG_ADDR_IN == `ASRT_ERRST_ADDR);
	wire rxbuf_rd = REG_RD_IN && (REG_ADDR_IN == `ASRT_RXBUF_ADDR);
	wire tx_rst = !power || !txe_s_q;
	wire tx_run = pwr_rdy_q && txe_s_q;
	wire rx_run = pwr_rdy_q && rxe_s_q;

	logic [7:0] rd_mux;
	always_comb
	begin
		if (REG_ADDR_IN == `ASRT_MODE_ADDR)
			rd_mux = mode_q;
		else if (REG_ADDR_IN == `ASRT_HOLD_ADDR)
			rd_mux = hold_q;
		else if (REG_ADDR_IN == `ASRT_RXBUF_ADDR)
			rd_mux = fifo_q[fifo_rp_q];
		else if (REG_ADDR_IN == `ASRT_ERRST_ADDR)
			rd_mux = {5'h00, err_q};
		else if (REG_ADDR_IN == `ASRT_TXST_ADDR)
			rd_mux = {6'h00, hold_full_q, tx_busy_q};
		else
			rd_mux = 8'h00;
	end

	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			mode_q <= `ASRT_MODE_RST;
			hold_q <= `ASRT_HOLD_RST;
			rdata_q <= 8'h00;
		end
		else
		begin
			mode_q <= mode_wr ? REG_WDATA_IN : mode_q;
			hold_q <= hold_wr ? REG_WDATA_IN : hold_q;
			rdata_q <= REG_RD_IN ? rd_mux : rdata_q;
		end
	end

	// Internal clock gate and enable synchronisation to the base tick
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			pwr_rdy_q <= 1'b0;
			txe_s_q <= 1'b0;
			rxe_s_q <= 1'b0;
		end
		else if (!power)
		begin
			pwr_rdy_q <= 1'b0;
			txe_s_q <= 1'b0;
			rxe_s_q <= 1'b0;
		end
		else if (BASE_TICK_IN)
		begin
			pwr_rdy_q <= 1'b1;
			txe_s_q <= pwr_rdy_q && mode_q[`ASRT_TXE_BIT];
			rxe_s_q <= pwr_rdy_q && mode_q[`ASRT_RXE_BIT];
		end
	end

	// Transmit frame: start, data, optional parity, stop bits, ones beyond
	wire [7:0] tx_ord = wire_order(hold_q, cl, MSB_FIRST_IN);
	wire tx_par = par_sel[1] & (^tx_ord ^ ~par_sel[0]);
	wire tx_has_par = par_sel != `ASRT_PAR_NONE;
	wire [3:0] tx_nb = 4'd1 + (cl ? 4'd8 : 4'd7) + {3'd0, tx_has_par} + (sl ? 4'd2 : 4'd1);
	logic [11:0] tx_frame;
	always_comb
	begin
		tx_frame = 12'hFFF;
		tx_frame[0] = 1'b0;
		tx_frame[7:1] = tx_ord[6:0];
		if (cl)
			tx_frame[8] = tx_ord[7];
		if (tx_has_par)
			tx_frame[cl ? 9 : 8] = tx_par;
	end
	wire tx_bit_end = BASE_TICK_IN && tx_busy_q && (tx_ovs_q == `ASRT_OVS_LAST);
	wire tx_end = tx_bit_end && (tx_left_q == 4'd0);
	wire tx_load = BASE_TICK_IN && tx_run && hold_full_q && (!tx_busy_q || tx_end);

	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			hold_full_q <= 1'b0;
		else if (tx_rst)
			hold_full_q <= 1'b0;
		else if (hold_wr)
			hold_full_q <= 1'b1;
		else if (tx_load)
			hold_full_q <= 1'b0;
	end

	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			tx_busy_q <= 1'b0;
			tx_frame_q <= 12'hFFF;
			tx_left_q <= 4'd0;
			tx_ovs_q <= 4'd0;
			tx_out_q <= 1'b1;
			tx_irq_q <= 1'b0;
		end
		else if (tx_rst)
		begin
			tx_busy_q <= 1'b0;
			tx_frame_q <= 12'hFFF;
			tx_left_q <= 4'd0;
			tx_ovs_q <= 4'd0;
			tx_out_q <= 1'b1;
			tx_irq_q <= 1'b0;
		end
		else
		begin
			tx_irq_q <= tx_end;
			if (tx_load)
			begin
				tx_busy_q <= 1'b1;
				tx_frame_q <= tx_frame;
				tx_left_q <= tx_nb - 4'd1;
				tx_ovs_q <= 4'd0;
				tx_out_q <= tx_frame[0];
			end
			else if (tx_end)
			begin
				tx_busy_q <= 1'b0;
				tx_out_q <= 1'b1;
			end
			else if (tx_bit_end)
			begin
				tx_frame_q <= {1'b1, tx_frame_q[11:1]};
				tx_out_q <= tx_frame_q[1];
				tx_left_q <= tx_left_q - 4'd1;
				tx_ovs_q <= 4'd0;
			end
			else if (BASE_TICK_IN && tx_busy_q)
				tx_ovs_q <= tx_ovs_q + 4'd1;
		end
	end

	// Receive input: two-stage synchroniser, forced high while powered off
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end
		else
		begin
			rx_s1_q <= SERIAL_IN_PIN_IN;
			rx_s2_q <= rx_s1_q;
		end
	end
	wire rx_lvl = power ? rx_s2_q : 1'b1;

	wire rx_samp = BASE_TICK_IN && (rx_ovs_q == `ASRT_OVS_LAST);
	wire [2:0] rx_last = cl ? 3'd7 : 3'd6;
	wire rx_stop_ev = rx_run && rx_samp && (rx_st_q == RX_STOP);
	wire [7:0] rx_ord = cl ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
	wire [7:0] rx_data = MSB_FIRST_IN ? rev8(rx_ord) : rx_ord;
	wire rx_perr = par_sel[1] && ((^rx_ord ^ rx_par_q) == par_sel[0]);
	wire rx_ferr = !rx_lvl;
	wire fifo_in_ready = fifo_cnt_q != 2'd2;
	wire rx_ovr = !fifo_in_ready;
	wire rx_any_err = rx_perr || rx_ferr || rx_ovr;
	wire fifo_push = rx_stop_ev && fifo_in_ready;
	wire fifo_out_valid = fifo_cnt_q != 2'd0;
	wire fifo_pop = rxbuf_rd && fifo_out_valid;

	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			rx_st_q <= RX_IDLE;
			rx_ovs_q <= 4'd0;
			rx_nb_q <= 3'd0;
			rx_sh_q <= 8'hFF;
			rx_par_q <= 1'b0;
		end
		else if (!rx_run)
		begin
			rx_st_q <= RX_IDLE;
			rx_ovs_q <= 4'd0;
			rx_nb_q <= 3'd0;
		end
		else if (BASE_TICK_IN)
		begin
			rx_ovs_q <= rx_ovs_q + 4'd1;
			case (rx_st_q)
				RX_IDLE:
				begin
					rx_ovs_q <= 4'd0;
					if (!rx_lvl)
						rx_st_q <= RX_START;
				end
				RX_START:
					if (rx_ovs_q == `ASRT_OVS_MID)
					begin
						rx_ovs_q <= 4'd0;
						rx_nb_q <= 3'd0;
						rx_st_q <= rx_lvl ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (rx_samp)
					begin
						rx_sh_q <= {rx_lvl, rx_sh_q[7:1]};
						rx_nb_q <= rx_nb_q + 3'd1;
						if (rx_nb_q == rx_last)
							rx_st_q <= (par_sel == `ASRT_PAR_NONE) ? RX_STOP : RX_PAR;
					end
				RX_PAR:
					if (rx_samp)
					begin
						rx_par_q <= rx_lvl;
						rx_st_q <= RX_STOP;
					end
				RX_STOP:
					if (rx_samp)
						rx_st_q <= RX_IDLE;
				default:
					rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// Error flags: cleared by a status read, a new error wins over the clear
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			err_q <= 3'b000;
			rx_done_irq_q <= 1'b0;
			rx_err_irq_q <= 1'b0;
		end
		else if (!power || !rxe_s_q)
		begin
			err_q <= 3'b000;
			rx_done_irq_q <= 1'b0;
			rx_err_irq_q <= 1'b0;
		end
		else
		begin
			err_q <= (err_rd ? 3'b000 : err_q) |
				({3{rx_stop_ev}} & {rx_perr, rx_ferr, rx_ovr});
			rx_done_irq_q <= rx_stop_ev && (!rx_any_err || isrm);
			rx_err_irq_q <= rx_stop_ev && rx_any_err && !isrm;
		end
	end

	// Two-entry receive buffer; a push into a full buffer is an overrun
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			fifo_q <= '{`ASRT_RXBUF_RST, `ASRT_RXBUF_RST};
			fifo_wp_q <= 1'b0;
			fifo_rp_q <= 1'b0;
			fifo_cnt_q <= 2'd0;
		end
		else if (!power)
		begin
			fifo_q <= '{`ASRT_RXBUF_RST, `ASRT_RXBUF_RST};
			fifo_wp_q <= 1'b0;
			fifo_rp_q <= 1'b0;
			fifo_cnt_q <= 2'd0;
		end
		else
		begin
			if (fifo_push)
			begin
				fifo_q[fifo_wp_q] <= rx_data;
				fifo_wp_q <= !fifo_wp_q;
			end
			if (fifo_pop)
				fifo_rp_q <= !fifo_rp_q;
			fifo_cnt_q <= fifo_cnt_q + {1'b0, fifo_push} - {1'b0, fifo_pop};
		end
	end

	assign REG_RDATA_OUT = rdata_q;
	assign SERIAL_OUT_PIN_OUT = tx_out_q;
	assign TRANSMIT_DONE_IRQ_OUT = tx_irq_q;
	assign RECEIVE_DONE_IRQ_OUT = rx_done_irq_q;
	assign RECEIVE_ERROR_IRQ_OUT = rx_err_irq_q;

	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	a_write_sets_full: assert property ((hold_wr && !tx_rst) |=> hold_full_q)
		else $error("holding write did not set full");
	a_lsb7_bits: assert property ((tx_load && !cl && !MSB_FIRST_IN) |=>
		(tx_frame_q[7:1] == $past(hold_q[6:0])) && !tx_out_q)
		else $error("7-bit lsb frame wrong");
	a_msb7_bits: assert property ((tx_load && !cl && MSB_FIRST_IN) |=>
		(tx_frame_q[1] == $past(hold_q[7])) && (tx_frame_q[7] == $past(hold_q[1])))
		else $error("7-bit msb frame wrong");
	a_next_before_irq: assert property ((tx_end && hold_full_q && tx_run) |=>
		tx_busy_q && !hold_full_q && TRANSMIT_DONE_IRQ_OUT && !SERIAL_OUT_PIN_OUT)
		else $error("back-to-back load missed");
	a_power_clears: assert property (!power |=>
		(err_q == 3'b000) && !hold_full_q && !tx_busy_q && (fifo_cnt_q == 2'd0))
		else $error("power off did not clear state");
	a_power_line_high: assert property (!power |=> SERIAL_OUT_PIN_OUT)
		else $error("line not high with power off");
	a_power_wait: assert property (($rose(power) && !BASE_TICK_IN) |=> !pwr_rdy_q)
		else $error("clock supplied too early");
	a_txe_reset: assert property ((power && !mode_q[`ASRT_TXE_BIT] && BASE_TICK_IN)
		|=> ##1 !tx_busy_q && !hold_full_q)
		else $error("transmit circuit not reset");
	a_even_parity: assert property ((tx_load && cl && par_sel == `ASRT_PAR_EVEN) |=>
		tx_frame_q[9] == ^$past(hold_q))
		else $error("even parity bit wrong");
	a_zero_no_pe: assert property ((par_sel == `ASRT_PAR_ZERO) |=> !$rose(err_q[`ASRT_PE_BIT]))
		else $error("parity flagged under zero parity");
	a_stop_count: assert property ((tx_load && cl && !tx_has_par && !sl) |=> tx_left_q == 4'd9)
		else $error("frame length wrong");
	a_err_routing: assert property ((rx_stop_ev && rx_any_err) |=>
		(RECEIVE_ERROR_IRQ_OUT != $past(isrm)) && (RECEIVE_DONE_IRQ_OUT == $past(isrm)))
		else $error("error routed wrongly");

	c_tx_frame: cover property (tx_end ##1 TRANSMIT_DONE_IRQ_OUT);
	c_rx_ok: cover property (RECEIVE_DONE_IRQ_OUT && err_q == 3'b000);
	c_rx_overrun: cover property (rx_stop_ev && rx_ovr);
	c_back_to_back: cover property (tx_end && tx_load);
endmodule

/* File: shared/asrt_defines.svh */
// Register map, field positions, reset values and bit timing of the serial core
`ifndef ASRT_DEFINES_SVH
`define ASRT_DEFINES_SVH
`define ASRT_MODE_ADDR 16'hFF90
`define ASRT_RXBUF_ADDR 16'hFF91
`define ASRT_HOLD_ADDR 16'hFF92
`define ASRT_ERRST_ADDR 16'hFF93
`define ASRT_TXST_ADDR 16'hFF95
`define ASRT_MODE_RST 8'h01
`define ASRT_HOLD_RST 8'hFF
`define ASRT_RXBUF_RST 8'hFF
`define ASRT_POWER_BIT 7
`define ASRT_TXE_BIT 6
`define ASRT_RXE_BIT 5
`define ASRT_PS_HI_BIT 4
`define ASRT_PS_LO_BIT 3
`define ASRT_CL_BIT 2
`define ASRT_SL_BIT 1
`define ASRT_ISRM_BIT 0
`define ASRT_PE_BIT 2
`define ASRT_FE_BIT 1
`define ASRT_OVE_BIT 0
`define ASRT_PAR_NONE 2'b00
`define ASRT_PAR_ZERO 2'b01
`define ASRT_PAR_ODD 2'b10
`define ASRT_PAR_EVEN 2'b11
`define ASRT_OVS_LAST 4'hF
`define ASRT_OVS_MID 4'h7
`endif

/* File: shared/asrt_pkg.sv */
// Types shared by the serial core
package asrt_pkg;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asrt_rx_state_t;
endpackage

/* File: sim/asrt_far_node.sv */
// Remote serial node: sends frames to the core and captures frames from it
`timescale 1ns/100ps
module asrt_far_node
(
	// Clock and base tick
	input wire logic clk_in,
	input wire logic tick_in,
	// Serial lines
	input wire logic line_in,
	output logic line_out
);
	int n_cap = 11;
	logic [15:0] cap_q[$];
	initial line_out = 1'b1;
	task automatic ticks(input int k);
		repeat (k) @(posedge clk_in iff tick_in);
	endtask
	// Start bit, then bits[0..n-1], then one idle bit time
	task automatic send(input logic [15:0] bits, input int n);
		line_out <= 1'b0;
		ticks(16);
		for (int i = 0; i < n; i++)
		begin
			line_out <= bits[i];
			ticks(16);
		end
		line_out <= 1'b1;
		ticks(16);
	endtask
	initial
	begin : grab
		logic [15:0] w;
		forever
		begin
			@(posedge clk_in iff (tick_in && line_in === 1'b0));
			w = '0;
			ticks(8);
			for (int i = 0; i < n_cap; i++)
			begin
				ticks(16);
				w[i] = line_in;
			end
			cap_q.push_back(w);
		end
	end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench of the serial core against a frame model
`timescale 1ns/100ps
`include "asrt_defines.svh"
module tb_top
	import asrt_pkg::*;
;
	logic clk = 0, arst_n = 0, tick = 0, msb = 0, wen = 0, ren = 0;
	logic [15:0] addr = '0;
	logic [7:0] wdata = '0, rdata, v, d, d2;
	logic [7:0] q[3];
	logic [4:0] cur = '0;
	logic [15:0] e, e2;
	logic tx, rx, rdone, rerr, tdone;
	int n_fail = 0, samples_checked = 0, n = 0, seed = 49;
	int n_rd = 0, n_re = 0, n_td = 0, a, b, cyc = 0;
	logic [15:0] ra[6] = '{`ASRT_MODE_ADDR, `ASRT_RXBUF_ADDR, `ASRT_HOLD_ADDR,
		`ASRT_ERRST_ADDR, `ASRT_TXST_ADDR, 16'hFF94};
	logic [7:0] rv[6] = '{`ASRT_MODE_RST, `ASRT_RXBUF_RST, `ASRT_HOLD_RST, 8'h00, 8'h00, 8'h00};
	logic [4:0] tm[6] = '{5'h00, 5'h00, 5'h16, 5'h1C, 5'h0C, 5'h0A};
	logic tmsb[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	logic [4:0] rm[6] = '{5'h1C, 5'h14, 5'h15, 5'h0C, 5'h00, 5'h00};
	logic rmsb[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic rbad[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [7:0] rex[6] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00};
	always #12.5 clk = ~clk;
	always @(negedge clk) tick <= ~tick;
	asrt_core dut (.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .BASE_TICK_IN(tick),
		.MSB_FIRST_IN(msb), .REG_ADDR_IN(addr), .REG_WR_IN(wen), .REG_RD_IN(ren),
		.REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .SERIAL_IN_PIN_IN(rx),
		.SERIAL_OUT_PIN_OUT(tx), .RECEIVE_DONE_IRQ_OUT(rdone),
		.RECEIVE_ERROR_IRQ_OUT(rerr), .TRANSMIT_DONE_IRQ_OUT(tdone));
	asrt_far_node far (.clk_in(clk), .tick_in(tick), .line_in(tx), .line_out(rx));
	always @(posedge clk)
	begin
		n_rd += (rdone === 1'b1);
		n_re += (rerr === 1'b1);
		n_td += (tdone === 1'b1);
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			close_out();
		end
	end
	task automatic miss(input string s);
		n_fail++;
		$display("[FAIL] %0t %s", $time, s);
	endtask
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] x);
		samples_checked++;
		if (g !== x)
			miss("register value");
	endtask
	task automatic chk_frame(input logic [15:0] g, input logic [15:0] x);
		samples_checked++;
		if (g !== x)
			miss("serial frame");
	endtask
	task automatic chk_cnt(input int g, input int x);
		samples_checked++;
		if (g != x)
			miss("event count");
	endtask
	task automatic wr(input logic [15:0] ad, input logic [7:0] dt);
		@(negedge clk);
		addr = ad;
		wdata = dt;
		wen = 1'b1;
		@(negedge clk);
		wen = 1'b0;
	endtask
	task automatic rd(input logic [15:0] ad, output logic [7:0] dt);
		@(negedge clk);
		addr = ad;
		ren = 1'b1;
		@(negedge clk);
		ren = 1'b0;
		dt = rdata;
	endtask
	// Disable, change frame settings, enable again
	task automatic setup(input logic [4:0] m, input logic mf);
		wr(`ASRT_MODE_ADDR, {3'b100, cur});
		far.ticks(2);
		wr(`ASRT_MODE_ADDR, {3'b100, m});
		msb = mf;
		cur = m;
		wr(`ASRT_MODE_ADDR, {3'b111, m});
		far.ticks(4);
	endtask
	// Bits after the start bit: data, parity, stops
	function automatic logic [15:0] frame(input logic [7:0] dt, input logic [4:0] m,
		input logic mf, output int nb);
		logic p;
		frame = '0;
		p = 1'b0;
		nb = 0;
		for (int i = 0; i < (m[2] ? 8 : 7); i++)
		begin
			frame[nb] = mf ? dt[7 - i] : dt[i];
			p ^= frame[nb];
			nb++;
		end
		if (m[4:3] != 2'b00)
		begin
			frame[nb] = m[4] & (m[3] ? p : ~p);
			nb++;
		end
		frame[nb] = 1'b1;
		nb += m[1] ? 2 : 1;
		if (m[1])
			frame[nb - 1] = 1'b1;
	endfunction
	task automatic wait_frames(input int k);
		for (int c = 0; c < 3000 && far.cap_q.size() < k; c++)
			@(posedge clk);
		if (far.cap_q.size() < k)
		begin
			miss("frame timeout");
			while (far.cap_q.size() < k)
				far.cap_q.push_back(16'h0000);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			rd(ra[i], v);
			chk_reg(v, rv[i]);
		end
		$display("test reset values done");
		wr(`ASRT_MODE_ADDR, 8'h80);
		far.ticks(2);
		for (int i = 0; i < 6; i++)
		begin
			setup(tm[i], tmsb[i]);
			d = 8'($random(seed));
			e = frame(d, tm[i], tmsb[i], n);
			far.n_cap = n;
			wr(`ASRT_HOLD_ADDR, d);
			wait_frames(1);
			chk_frame(far.cap_q.pop_front(), e);
			// Let the last stop bit finish so every frame gives its done pulse
			far.ticks(16);
		end
		$display("test frame formats done");
		setup(5'h1C, 1'b0);
		d = 8'($random(seed));
		d2 = d ^ 8'h5A;
		e = frame(d, 5'h1C, 1'b0, n);
		e2 = frame(d2, 5'h1C, 1'b0, n);
		far.n_cap = n;
		wr(`ASRT_HOLD_ADDR, d);
		v = 8'h02;
		for (int c = 0; c < 200 && v[1] !== 1'b0; c++)
			rd(`ASRT_TXST_ADDR, v);
		wr(`ASRT_HOLD_ADDR, d2);
		wait_frames(2);
		chk_frame(far.cap_q.pop_front(), e);
		chk_frame(far.cap_q.pop_front(), e2);
		far.ticks(16);
		chk_cnt(n_td, 8);
		$display("test back to back done");
		for (int i = 0; i < 6; i++)
		begin
			setup(rm[i], rmsb[i]);
			d = 8'($random(seed));
			e = frame(d, rm[i], rmsb[i], n);
			if (rbad[i])
				e[n - 2] = ~e[n - 2];
			a = n_rd;
			b = n_re;
			far.send(e, n);
			chk_cnt(n_rd - a, (rex[i] == 0 || rm[i][0]) ? 1 : 0);
			chk_cnt(n_re - b, (rex[i] != 0 && !rm[i][0]) ? 1 : 0);
			rd(`ASRT_ERRST_ADDR, v);
			chk_reg(v, rex[i]);
			rd(`ASRT_RXBUF_ADDR, v);
			if (rex[i] == 0)
				chk_reg(v, d & (rm[i][2] ? 8'hFF : rmsb[i] ? 8'hFE : 8'h7F));
		end
		for (int j = 0; j < 3; j++)
		begin
			q[j] = 8'($random(seed)) & 8'hFE;
			e = frame(q[j], 5'h00, 1'b1, n);
			far.send(e, n);
		end
		rd(`ASRT_ERRST_ADDR, v);
		chk_reg(v, 8'h01);
		rd(`ASRT_RXBUF_ADDR, v);
		chk_reg(v, q[0]);
		$display("test receive done");
		wr(`ASRT_HOLD_ADDR, 8'h3C);
		far.ticks(40);
		wr(`ASRT_MODE_ADDR, {3'b000, cur});
		@(negedge clk);
		chk_reg({7'h00, tx}, 8'h01);
		rd(`ASRT_TXST_ADDR, v);
		chk_reg(v, 8'h00);
		rd(`ASRT_RXBUF_ADDR, v);
		chk_reg(v, `ASRT_RXBUF_RST);
		repeat (400) @(posedge clk);
		$display("test power off done");
		close_out();
	end
endmodule
